// ==== hw/ccb_consts.svh ====
// constants for the coprocessor condition branch block
`ifndef CCB_CONSTS_SVH
`define CCB_CONSTS_SVH
`define CCB_OP_FPU      6'h11
`define CCB_OP_CP_TWO   6'h12
`define CCB_SUBOP       5'h08
`define CCB_OP_MSB      31
`define CCB_OP_LSB      26
`define CCB_SUB_MSB     25
`define CCB_SUB_LSB     21
`define CCB_SEL_MSB     20
`define CCB_SEL_LSB     18
`define CCB_NUL_BIT     17
`define CCB_POL_BIT     16
`define CCB_OFF_MSB     15
`define CCB_SLOT_STEP   32'h0000_0004
`define CCB_REG_CTRL    8'h00
`define CCB_REG_STATUS  8'h04
`define CCB_REG_CLEAR   8'h08
`define CCB_REG_ENABLE  8'h0C
`define CCB_REG_CODES   8'h10
`define CCB_REG_TARGET  8'h14
`define CCB_CTRL_FPU_USE 0
`define CCB_CTRL_CP_USE  1
`define CCB_CTRL_FPU_HAS 2
`define CCB_CTRL_CP_HAS  3
`define CCB_CTRL_ONE_CODE 4
`define CCB_CTRL_RST    5'h0F
`define CCB_EVT_TAKEN   0
`define CCB_EVT_NULL    1
`define CCB_EVT_UNUSE   2
`define CCB_EVT_RSVD    3
`define CCB_EVT_UNIMPL  4
`define CCB_RESP_OKAY   2'h0
`define CCB_RESP_SLVERR 2'h2
`endif

// ==== hw/ccb_dec_if.sv ====
// carrier between the branch control and the instruction decoder
`timescale 1ns/1ps
interface ccb_dec_if;
  logic [31:0] word;
  logic [31:0] pc;
  logic        is_fpu;
  logic        is_cp_two;
  logic        nullify_delay_bit;
  logic        polarity_bit;
  logic [2:0]  condition_select;
  logic [31:0] target;
  modport ctl (output word, pc, input is_fpu, is_cp_two, nullify_delay_bit, polarity_bit,
               condition_select, target);
  modport dec (input word, pc, output is_fpu, is_cp_two, nullify_delay_bit, polarity_bit,
               condition_select, target);
endinterface : ccb_dec_if

// ==== hw/ccb_decode.sv ====
// field decoder and target adder for condition branches
`timescale 1ns/1ps
`include "ccb_consts.svh"
module ccb_decode (
  ccb_dec_if.dec dif
);
  import ccb_pkg::*;

  function automatic logic [31:0] slot_target(input logic [31:0] pc, input logic [15:0] off);
    logic [31:0] disp;
    disp = {{14{off[15]}}, off, 2'b00};
    slot_target = pc + `CCB_SLOT_STEP + disp;
  endfunction : slot_target

  function automatic logic op_is(input logic [31:0] w, input logic [5:0] op);
    op_is = (w[`CCB_OP_MSB:`CCB_OP_LSB] == op) && (w[`CCB_SUB_MSB:`CCB_SUB_LSB] == `CCB_SUBOP);
  endfunction : op_is

  always_comb begin
    dif.is_fpu            = op_is(dif.word, `CCB_OP_FPU);
    dif.is_cp_two         = op_is(dif.word, `CCB_OP_CP_TWO);
    dif.condition_select  = dif.word[`CCB_SEL_MSB:`CCB_SEL_LSB];
    dif.nullify_delay_bit = dif.word[`CCB_NUL_BIT];
    dif.polarity_bit      = dif.word[`CCB_POL_BIT];
    // relative to the delay slot, never to the branch itself
    dif.target = slot_target(dif.pc, dif.word[`CCB_OFF_MSB:0]);
  end
endmodule : ccb_decode

// ==== hw/ccb_pkg.sv ====
// types for the coprocessor condition branch block
package ccb_pkg;
  typedef enum logic [1:0] {CCB_EXC_NONE, CCB_EXC_UNUSABLE, CCB_EXC_RESERVED,
                            CCB_EXC_UNIMPL} ccb_exc_type;
  typedef enum logic {CCB_ST_IDLE, CCB_ST_SLOT} ccb_state_type;
endpackage : ccb_pkg

// ==== hw/ccb_top.sv ====
// condition branch control with register slave, condition codes and interrupt
`timescale 1ns/1ps
`include "ccb_consts.svh"
module ccb_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 RESET_N,
  input  wire logic                 INSTR_VALID,
  input  wire logic [31:0]          INSTR_WORD,
  input  wire logic [31:0]          INSTR_PC,
  input  wire logic                 FCMP_WR_EN,
  input  wire logic [2:0]           FCMP_WR_SEL,
  input  wire logic                 FCMP_WR_VAL,
  input  wire logic [7:0]           CP_TWO_COND,
  output logic                      REDIRECT_VALID,
  output logic [31:0]               REDIRECT_PC,
  output logic                      NULLIFY_SLOT,
  output logic                      EXC_VALID,
  output ccb_pkg::ccb_exc_type      EXC_CODE,
  output logic                      IRQ,
  input  wire logic [ADDR_W-1:0]    S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0]    S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY
);
  import ccb_pkg::*;

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  ccb_dec_if dif ();
  assign dif.word = INSTR_WORD;
  assign dif.pc   = INSTR_PC;
  ccb_decode u_decode (
    .dif (dif.dec)
  );

  // branch sequencing state
  ccb_state_type state_q, state_d;
  logic          taken_q, taken_d;
  logic          likely_q, likely_d;
  logic [31:0]   target_q, target_d;
  logic          redir_q, redir_d;
  logic [31:0]   redir_pc_q, redir_pc_d;
  logic          null_q, null_d;
  logic          exc_q, exc_d;
  ccb_exc_type   exc_code_q, exc_code_d;
  logic [7:0]    fcc_q, fcc_d;
  logic [4:0]    ctrl_q, ctrl_d;
  logic [4:0]    status_q, status_d;
  logic [4:0]    irq_en_q, irq_en_d;
  logic [4:0]    evt;
  logic [4:0]    clr_mask;
  logic          is_branch;
  logic          cond_bit;
  logic          cond_taken;
  logic          accept;
  ccb_exc_type   exc_sel;

  assign is_branch  = dif.is_fpu || dif.is_cp_two;
  // float forms read the compare codes, the others the coprocessor-2 lines
  assign cond_bit   = dif.is_fpu ? fcc_q[dif.condition_select]
                                 : CP_TWO_COND[dif.condition_select];
  assign cond_taken = (cond_bit == dif.polarity_bit);

  // reserved beats unusable beats unimplemented
  always_comb begin
    exc_sel = CCB_EXC_NONE;
    if (dif.is_fpu) begin
      if (!ctrl_q[`CCB_CTRL_FPU_HAS]) begin
        exc_sel = CCB_EXC_RESERVED;
      end else if (!ctrl_q[`CCB_CTRL_FPU_USE]) begin
        exc_sel = CCB_EXC_UNUSABLE;
      end else if (ctrl_q[`CCB_CTRL_ONE_CODE] && (dif.condition_select != 3'h0)) begin
        exc_sel = CCB_EXC_UNIMPL;
      end
    end else if (dif.is_cp_two) begin
      if (!ctrl_q[`CCB_CTRL_CP_HAS]) begin
        exc_sel = CCB_EXC_RESERVED;
      end else if (!ctrl_q[`CCB_CTRL_CP_USE]) begin
        exc_sel = CCB_EXC_UNUSABLE;
      end
    end
  end

  // the delay slot is never decoded as a branch: software keeps branches out of it
  assign accept = (state_q == CCB_ST_IDLE) && INSTR_VALID && is_branch &&
                  (exc_sel == CCB_EXC_NONE);

  always_comb begin
    state_d    = state_q;
    taken_d    = taken_q;
    likely_d   = likely_q;
    target_d   = target_q;
    redir_d    = 1'b0;
    redir_pc_d = redir_pc_q;
    null_d     = 1'b0;
    exc_d      = 1'b0;
    exc_code_d = CCB_EXC_NONE;
    evt        = 5'h00;
    case (state_q)
      CCB_ST_IDLE: begin
        if (INSTR_VALID && is_branch) begin
          if (exc_sel != CCB_EXC_NONE) begin
            exc_d      = 1'b1;
            exc_code_d = exc_sel;
            evt[`CCB_EVT_UNUSE]  = (exc_sel == CCB_EXC_UNUSABLE);
            evt[`CCB_EVT_RSVD]   = (exc_sel == CCB_EXC_RESERVED);
            evt[`CCB_EVT_UNIMPL] = (exc_sel == CCB_EXC_UNIMPL);
          end else begin
            taken_d  = cond_taken;
            likely_d = dif.nullify_delay_bit;
            target_d = dif.target;
            state_d  = CCB_ST_SLOT;
          end
        end
      end
      CCB_ST_SLOT: begin
        if (INSTR_VALID) begin
          state_d = CCB_ST_IDLE;
          if (taken_q) begin
            redir_d    = 1'b1;
            redir_pc_d = target_q;
            evt[`CCB_EVT_TAKEN] = 1'b1;
          end else if (likely_q) begin
            null_d = 1'b1;
            evt[`CCB_EVT_NULL] = 1'b1;
          end
        end
      end
      default: state_d = CCB_ST_IDLE;
    endcase
  end

  // only the compare path may touch the codes
  always_comb begin
    fcc_d = fcc_q;
    if (FCMP_WR_EN) begin
      fcc_d[FCMP_WR_SEL] = FCMP_WR_VAL;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= CCB_ST_IDLE;
      taken_q    <= 1'b0;
      likely_q   <= 1'b0;
      target_q   <= 32'h0000_0000;
      redir_q    <= 1'b0;
      redir_pc_q <= 32'h0000_0000;
      null_q     <= 1'b0;
      exc_q      <= 1'b0;
      exc_code_q <= CCB_EXC_NONE;
      fcc_q      <= 8'h00;
    end else begin
      state_q    <= state_d;
      taken_q    <= taken_d;
      likely_q   <= likely_d;
      target_q   <= target_d;
      redir_q    <= redir_d;
      redir_pc_q <= redir_pc_d;
      null_q     <= null_d;
      exc_q      <= exc_d;
      exc_code_q <= exc_code_d;
      fcc_q      <= fcc_d;
    end
  end

  assign REDIRECT_VALID = redir_q;
  assign REDIRECT_PC    = redir_pc_q;
  assign NULLIFY_SLOT   = null_q;
  assign EXC_VALID      = exc_q;
  assign EXC_CODE       = exc_code_q;
  assign IRQ            = |(status_q & irq_en_q);

  // register slave: address and data may arrive in either order
  logic              aw_have_q, aw_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic              w_have_q, w_have_d;
  logic [31:0]       wdata_q, wdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              bvalid_q, bvalid_d;
  logic [1:0]        bresp_q, bresp_d;
  logic              rvalid_q, rvalid_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [1:0]        rresp_q, rresp_d;
  logic              do_write;
  logic [7:0]        waddr8;
  logic [7:0]        raddr8;

  assign S_AXI_AWREADY = !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY  = !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY = !rvalid_q;
  assign do_write      = aw_have_q && w_have_q && !bvalid_q;
  assign waddr8        = 8'(awaddr_q);
  assign raddr8        = 8'(S_AXI_ARADDR);

  always_comb begin
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    ctrl_d    = ctrl_q;
    irq_en_d  = irq_en_q;
    clr_mask  = 5'h00;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_have_d = 1'b1;
      awaddr_d  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_have_d = 1'b1;
      wdata_d  = S_AXI_WDATA;
      wstrb_d  = S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `CCB_RESP_OKAY;
      if (waddr8 == `CCB_REG_CTRL) begin
        if (wstrb_q[0]) ctrl_d = wdata_q[4:0];
      end else if (waddr8 == `CCB_REG_CLEAR) begin
        if (wstrb_q[0]) clr_mask = wdata_q[4:0];
      end else if (waddr8 == `CCB_REG_ENABLE) begin
        if (wstrb_q[0]) irq_en_d = wdata_q[4:0];
      end else if ((waddr8 != `CCB_REG_STATUS) && (waddr8 != `CCB_REG_CODES) &&
                   (waddr8 != `CCB_REG_TARGET)) begin
        bresp_d = `CCB_RESP_SLVERR;
      end
    end else if (bvalid_q && S_AXI_BREADY) begin
      bvalid_d = 1'b0;
    end
    // a fresh event outlives a clear in the same cycle
    status_d = (status_q & ~clr_mask) | evt;
  end

  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_d = 1'b1;
      rresp_d  = `CCB_RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      if (raddr8 == `CCB_REG_CTRL) begin
        rdata_d[4:0] = ctrl_q;
      end else if (raddr8 == `CCB_REG_STATUS) begin
        rdata_d[4:0] = status_q;
      end else if (raddr8 == `CCB_REG_CLEAR) begin
        rdata_d = 32'h0000_0000;
      end else if (raddr8 == `CCB_REG_ENABLE) begin
        rdata_d[4:0] = irq_en_q;
      end else if (raddr8 == `CCB_REG_CODES) begin
        rdata_d[7:0] = fcc_q;
      end else if (raddr8 == `CCB_REG_TARGET) begin
        rdata_d = target_q;
      end else begin
        rresp_d = `CCB_RESP_SLVERR;
      end
    end else if (rvalid_q && S_AXI_RREADY) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CCB_RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `CCB_RESP_OKAY;
      ctrl_q    <= `CCB_CTRL_RST;
      status_q  <= 5'h00;
      irq_en_q  <= 5'h00;
    end else begin
      aw_have_q <= aw_have_d;
      awaddr_q  <= awaddr_d;
      w_have_q  <= w_have_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      ctrl_q    <= ctrl_d;
      status_q  <= status_d;
      irq_en_q  <= irq_en_d;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP  = bresp_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA  = rdata_q;
  assign S_AXI_RRESP  = rresp_q;

  // checks
  logic [31:0] disp_chk;
  logic        fcc_pick;
  logic        cp_pick;
  assign disp_chk = {{14{INSTR_WORD[15]}}, INSTR_WORD[15:0], 2'b00};
  assign fcc_pick = fcc_q[INSTR_WORD[20:18]];
  assign cp_pick  = CP_TWO_COND[INSTR_WORD[20:18]];

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    accept;
  endsequence
  sequence s_slot_hit;
    (state_q == CCB_ST_SLOT) && INSTR_VALID;
  endsequence

  a_enter_slot: assert property (s_accept |=> (state_q == CCB_ST_SLOT))
    else $error("accepted branch did not wait for its delay slot");
  a_slot_target: assert property (s_accept |=>
      target_q == ($past(INSTR_PC) + 32'h0000_0004 + $past(disp_chk)))
    else $error("branch target not relative to the delay slot");
  a_true_taken: assert property (s_accept and (INSTR_WORD[31:26] == `CCB_OP_FPU) and
      INSTR_WORD[16] |=> (taken_q == $past(fcc_pick)))
    else $error("true-polarity float branch took the wrong decision");
  a_false_taken: assert property (s_accept and (INSTR_WORD[31:26] == `CCB_OP_CP_TWO) and
      !INSTR_WORD[16] |=> (taken_q == !$past(cp_pick)))
    else $error("false-polarity coprocessor branch took the wrong decision");
  a_likely_nullify: assert property (s_slot_hit and !taken_q and likely_q |=>
      NULLIFY_SLOT && !REDIRECT_VALID ##1 !NULLIFY_SLOT)
    else $error("untaken likely branch failed to suppress its slot");
  a_mode_bits: assert property (s_accept |=> likely_q == $past(INSTR_WORD[17]))
    else $error("nullify bit not carried to the delay slot");
  a_redirect_slot: assert property (s_slot_hit and taken_q |=>
      REDIRECT_VALID && (REDIRECT_PC == $past(target_q)))
    else $error("redirect missing at the delay slot");
  a_no_early_redirect: assert property (REDIRECT_VALID |-> $past(state_q) == CCB_ST_SLOT)
    else $error("redirect issued outside a delay slot");
  a_exc_report: assert property ((state_q == CCB_ST_IDLE) && INSTR_VALID && is_branch &&
      (exc_sel != CCB_EXC_NONE) |=> EXC_VALID && (EXC_CODE == $past(exc_sel)) &&
      (state_q == CCB_ST_IDLE))
    else $error("branch exception not reported");
  a_unimpl_float: assert property (EXC_VALID && (EXC_CODE == CCB_EXC_UNIMPL) |->
      $past(INSTR_WORD[31:26]) == `CCB_OP_FPU)
    else $error("unimplemented operation raised by a coprocessor-2 branch");
  a_codes_compare: assert property (!FCMP_WR_EN |=> $stable(fcc_q))
    else $error("condition codes changed without a compare write");
  a_code_written: assert property (FCMP_WR_EN |=> fcc_q[$past(FCMP_WR_SEL)] == $past(FCMP_WR_VAL))
    else $error("compare write lost");
  a_sticky_set: assert property ((evt != 5'h00) |=> ((status_q & $past(evt)) == $past(evt)))
    else $error("event lost against a clear");
endmodule : ccb_top

// ==== test/ccb_cond_model.sv ====
// partner model: float compare code writes and coprocessor-2 condition lines
`timescale 1ns/1ps
module ccb_cond_model (
  input  wire logic       clk,
  output logic            fcmp_wr_en,
  output logic [2:0]      fcmp_wr_sel,
  output logic            fcmp_wr_val,
  output logic [7:0]      cp_two_cond
);
  initial begin
    fcmp_wr_en  = 1'b0;
    fcmp_wr_sel = 3'h0;
    fcmp_wr_val = 1'b0;
    cp_two_cond = 8'h00;
  end
  // codes move only through a one-cycle compare write pulse
  task automatic fcmp_write(input logic [2:0] sel, input logic val);
    @(posedge clk);
    fcmp_wr_en  <= 1'b1;
    fcmp_wr_sel <= sel;
    fcmp_wr_val <= val;
    @(posedge clk);
    fcmp_wr_en  <= 1'b0;
  endtask : fcmp_write
  // one line per select, moved only on an edge so a branch never sees it change
  task automatic set_cp(input logic [7:0] v);
    @(posedge clk);
    cp_two_cond <= v;
  endtask : set_cp
endmodule : ccb_cond_model

// ==== test/tb_coprocessor_condition_branch.sv ====
// self-checking bench for the condition branch block
`timescale 1ns/1ps
`include "ccb_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_coprocessor_condition_branch;
  import ccb_pkg::*;
  logic        ref_clk, reset_n, instr_valid, fcmp_wr_en, fcmp_wr_val, irq;
  logic [31:0] instr_word, instr_pc, redirect_pc, wdata, rdata;
  logic [2:0]  fcmp_wr_sel;
  logic [7:0]  cp_two_cond, awaddr, araddr;
  logic        redirect_valid, nullify_slot, exc_valid;
  ccb_exc_type exc_code;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  int          errors, n_tests, cyc;
  logic [7:0]  pat, cp;
  logic [31:0] w;
  logic        c, tk;

  ccb_cond_model u_cond (.clk(ref_clk), .fcmp_wr_en(fcmp_wr_en), .fcmp_wr_sel(fcmp_wr_sel),
    .fcmp_wr_val(fcmp_wr_val), .cp_two_cond(cp_two_cond));

  ccb_top #(.ADDR_W(8)) u_dut (.REF_CLK(ref_clk), .RESET_N(reset_n),
    .INSTR_VALID(instr_valid), .INSTR_WORD(instr_word), .INSTR_PC(instr_pc),
    .FCMP_WR_EN(fcmp_wr_en), .FCMP_WR_SEL(fcmp_wr_sel), .FCMP_WR_VAL(fcmp_wr_val),
    .CP_TWO_COND(cp_two_cond), .REDIRECT_VALID(redirect_valid), .REDIRECT_PC(redirect_pc),
    .NULLIFY_SLOT(nullify_slot), .EXC_VALID(exc_valid), .EXC_CODE(exc_code), .IRQ(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  initial ref_clk = 1'b0;
  always #12.5 ref_clk = ~ref_clk;

  task automatic end_of_test();
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // handshakes sampled at the rising edge, before the slave's flops move
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic       aw_p;
    logic       w_p;
    logic [1:0] resp;
    @(posedge ref_clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    aw_p = 1'b1;
    w_p  = 1'b1;
    while (aw_p || w_p) begin
      @(posedge ref_clk);
      if (aw_p && awready) begin
        aw_p = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    `CHK(resp, `CCB_RESP_OKAY)
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  resp;
    @(posedge ref_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    d    = rdata;
    resp = rresp;
    rready <= 1'b0;
    `CHK(d, exp)
    `CHK(resp, er)
  endtask : axi_rd

  // branch, optional idle gap, then a plain slot word; pulses checked at fixed cycles
  task automatic run_br(input logic [31:0] bw, pc, input int gap, input logic etk, enl,
                        input logic [1:0] ex);
    logic [31:0] tgt;
    tgt = pc + `CCB_SLOT_STEP + {{14{bw[15]}}, bw[15:0], 2'b00};
    @(posedge ref_clk);
    instr_valid <= 1'b1;
    instr_word  <= bw;
    instr_pc    <= pc;
    @(posedge ref_clk);
    instr_valid <= (gap == 0);
    instr_word  <= 32'h0000_0000;
    instr_pc    <= pc + `CCB_SLOT_STEP;
    #1;
    `CHK(exc_valid, ex != 2'h0)
    if (ex != 2'h0) `CHK(exc_code, ccb_exc_type'(ex))
    for (int i = 0; i < gap; i++) begin
      @(posedge ref_clk);
      instr_valid <= (i == gap - 1);
      #1;
      `CHK(redirect_valid | nullify_slot, 1'b0)
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    `CHK(redirect_valid, etk)
    `CHK(nullify_slot, enl)
    if (etk) `CHK(redirect_pc, tgt)
    @(posedge ref_clk);
    #1;
    `CHK(redirect_valid | nullify_slot, 1'b0)
  endtask : run_br

  initial begin
    {reset_n, instr_valid, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {instr_word, instr_pc, wdata, awaddr, araddr} = 112'h0;
    wstrb = 4'hF;
    pat = 8'hA5;
    cp = 8'h3C;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    axi_rd(`CCB_REG_CTRL, 32'h0000_000F, `CCB_RESP_OKAY);
    axi_rd(`CCB_REG_STATUS, 32'h0, `CCB_RESP_OKAY);
    axi_rd(`CCB_REG_CODES, 32'h0, `CCB_RESP_OKAY);
    axi_rd(8'h18, 32'h0, `CCB_RESP_SLVERR);
    for (int s = 0; s < 8; s++) u_cond.fcmp_write(s[2:0], pat[s]);
    u_cond.set_cp(cp);
    axi_wr(`CCB_REG_CODES, 32'h0);
    axi_rd(`CCB_REG_CODES, {24'h0, pat}, `CCB_RESP_OKAY);
    for (int u = 0; u < 2; u++) begin
      for (int s = 0; s < 8; s++) begin
        for (int m = 0; m < 4; m++) begin
          w = {(u == 1) ? `CCB_OP_CP_TWO : `CCB_OP_FPU, `CCB_SUBOP, s[2:0], m[1], m[0],
               s[0] ? 16'h8001 : 16'h7FFF};
          c = (u == 1) ? cp[s] : pat[s];
          tk = (c == m[0]);
          run_br(w, 32'h0040_0000 + s * 64, (m == 3) ? 2 : 0, tk, m[1] & !tk, 2'h0);
        end
      end
    end
    run_br({`CCB_OP_FPU, 5'h09, 5'h01, 16'h0010}, 32'h100, 0, 1'b0, 1'b0, 2'h0);
    run_br({6'h13, `CCB_SUBOP, 5'h01, 16'h0010}, 32'h100, 0, 1'b0, 1'b0, 2'h0);
    run_br({`CCB_OP_FPU, `CCB_SUBOP, 5'h01, 16'h0010}, 32'h1000, 0, 1'b1, 1'b0, 2'h0);
    axi_rd(`CCB_REG_TARGET, 32'h0000_1044, `CCB_RESP_OKAY);
    axi_wr(`CCB_REG_CTRL, 32'h0000_000E);
    run_br({`CCB_OP_FPU, `CCB_SUBOP, 5'h01, 16'h0010}, 32'h200, 0, 1'b0, 1'b0, 2'h1);
    axi_wr(`CCB_REG_CTRL, 32'h0000_0007);
    run_br({`CCB_OP_CP_TWO, `CCB_SUBOP, 5'h01, 16'h0010}, 32'h200, 0, 1'b0, 1'b0, 2'h2);
    axi_wr(`CCB_REG_CTRL, 32'h0000_001F);
    run_br({`CCB_OP_FPU, `CCB_SUBOP, 5'h0D, 16'h0010}, 32'h200, 0, 1'b0, 1'b0, 2'h3);
    axi_wr(`CCB_REG_CTRL, 32'h0000_000F);
    axi_rd(`CCB_REG_STATUS, 32'h0000_001F, `CCB_RESP_OKAY);
    #1;
    `CHK(irq, 1'b0)
    axi_wr(`CCB_REG_ENABLE, 32'h0000_0002);
    #1;
    `CHK(irq, 1'b1)
    axi_wr(`CCB_REG_CLEAR, 32'h0000_0002);
    #1;
    `CHK(irq, 1'b0)
    axi_rd(`CCB_REG_STATUS, 32'h0000_001D, `CCB_RESP_OKAY);
    axi_rd(`CCB_REG_CLEAR, 32'h0, `CCB_RESP_OKAY);
    axi_rd(`CCB_REG_ENABLE, 32'h0000_0002, `CCB_RESP_OKAY);
    end_of_test();
  end
endmodule : tb_coprocessor_condition_branch
